// File: rtl/flash_program_host.sv
// Purpose: host that issues program, erase and transfer frames to a flash
// Assumes: ready pin is high when the flash is idle; mode 0 serial clock
//          caller erases a page before program without erase
// Notes:   serial clock is a divided core clock, so one clock domain
//          a poll that runs out ends the command with done and timeout_err
//
// Behaviour
// - buffer load: opcode 84H/87H, 14 pad bits, 10-bit start position.
// - program with erase: 83H/86H, reserved bit, 13-bit page, 10 pad.
// - program without erase: 88H/89H, same page addressing, self-timed.
// - host must have erased the target page before program without erase.
// - page erase: 81H, reserved bit, 13-bit page, 10 pad bits.
// - block erase: 50H, reserved bit, upper ten page bits, 13 pad.
// - program through buffer: 82H/85H, page, start position, then data.
// - page to buffer copy: 53H/55H, page, 10 pad; starts on rise.
// - host keeps chip select low while clocking opcode and address.
// - auto rewrite: 58H/59H copies page to buffer, programs it back.
// - auto rewrite: last 10 address bits ignored, starts on rise.
// - frame starts on chip select fall; everything shifted msb first.
`timescale 1ns/10ps
`include "flash_cmd_regs.svh"

module flash_program_host
  import flash_cmd_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = 32'd1000000
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic cmd_valid,
  output logic      cmd_ready,
  input  wire cmd_s cmd,
  input  wire logic wr_valid,
  output logic      wr_ready,
  input  wire logic [7:0] wr_data,
  output logic      busy,
  output logic      done,
  output logic      timeout_err,
  output logic      flash_ready,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic rdy_busy_pin
);

  typedef enum logic [2:0] {
    st_idle,
    st_low,
    st_high,
    st_load,
    st_csgap,
    st_settle,
    st_poll
  } state_e;

  localparam logic [3:0]  half_cyc   = 4'(`SCK_HALF_CYC);
  localparam logic [31:0] gap_cyc    = 32'(`CS_HIGH_CYC);
  localparam logic [31:0] settle_cyc = 32'(`BUSY_SETTLE_CYC);
  localparam logic [31:0] limit_cyc  = 32'(TIMEOUT_CYCLES);

  state_e      state;
  cmd_s        cmd_q;
  logic [7:0]  sr;
  logic [2:0]  bit_cnt;
  logic [2:0]  hdr_cnt;
  logic [9:0]  data_left;
  logic [3:0]  div;
  logic [31:0] cnt;
  logic        rdy_meta;
  logic        rdy_s2;
  logic        rdy_s3;
  logic [23:0] addr;
  logic        half_done;
  logic        has_data;
  logic        self_timed;
  logic [9:0]  block_number_bits;

  function automatic logic [7:0] opcode(input cmd_s c);
    logic [7:0] o;
    o = 8'h00;
    case (c.op)
      op_buf_load:      o = c.buf2 ? `OPC_BUF2_LOAD : `OPC_BUF1_LOAD;
      op_prog_erase:    o = c.buf2 ? `OPC_BUF2_PROG_ER : `OPC_BUF1_PROG_ER;
      // page must already be erased; ordering is the caller's duty
      op_prog_no_erase: o = c.buf2 ? `OPC_BUF2_PROG_NE : `OPC_BUF1_PROG_NE;
      op_page_erase:    o = `OPC_PAGE_ERASE;
      op_block_erase:   o = `OPC_BLOCK_ERASE;
      op_prog_through:  o = c.buf2 ? `OPC_BUF2_PROG_TH : `OPC_BUF1_PROG_TH;
      op_page_copy:     o = c.buf2 ? `OPC_BUF2_COPY : `OPC_BUF1_COPY;
      op_auto_rewrite:  o = c.buf2 ? `OPC_BUF2_REWRITE : `OPC_BUF1_REWRITE;
      default:          o = `OPC_PAGE_ERASE;
    endcase
    return o;
  endfunction : opcode

  // low three page bits pick a page inside the block and are not sent
  assign block_number_bits = cmd_q.page_number_bits[12:3];

  // 24-bit address field for each frame kind
  always_comb begin
    case (cmd_q.op)
      op_buf_load:
        addr = {{`LOAD_PAD_BITS{1'b0}}, cmd_q.buffer_byte_position};
      op_prog_through:
        addr = {1'b0, cmd_q.page_number_bits,
                cmd_q.buffer_byte_position};
      op_block_erase:
        addr = {1'b0, block_number_bits,
                {`BLOCK_PAD_BITS{1'b0}}};
      default:
        // program, erase, copy and rewrite share page addressing
        addr = {1'b0, cmd_q.page_number_bits,
                {`PAGE_PAD_BITS{1'b0}}};
    endcase
  end

  always_comb begin
    has_data   = (cmd_q.op == op_buf_load) ||
                 (cmd_q.op == op_prog_through);
    self_timed = (cmd_q.op != op_buf_load);
    half_done  = (div == half_cyc - 4'h1);
  end

  // ready pin: three flops against metastability
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdy_meta <= 1'b0;
      rdy_s2   <= 1'b0;
      rdy_s3   <= 1'b0;
    end else begin
      rdy_meta <= rdy_busy_pin;
      rdy_s2   <= rdy_meta;
      rdy_s3   <= rdy_s2;
    end
  end

  // a change counts once the last two stages agree
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flash_ready <= 1'b0;
    end else if (rdy_s2 == rdy_s3) begin
      flash_ready <= rdy_s3;
    end
  end

  // no new frame while the flash still reports busy
  assign cmd_ready = (state == st_idle) && flash_ready;
  assign wr_ready  = (state == st_load);
  assign busy      = (state != st_idle);
  assign si        = sr[7];

  // divider for the serial clock halves
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      div <= 4'h0;
    end else if ((state == st_low || state == st_high) && !half_done) begin
      div <= div + 4'h1;
    end else begin
      div <= 4'h0;
    end
  end

  // frame sequencer
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state     <= st_idle;
      cmd_q     <= '0;
      sr        <= 8'h00;
      bit_cnt   <= 3'h0;
      hdr_cnt   <= 3'h0;
      data_left <= 10'h000;
      cs_n      <= 1'b1;
      sck       <= 1'b0;
      cnt       <= 32'h0;
    end else begin
      case (state)
        st_idle: begin
          sck <= 1'b0;
          cnt <= 32'h0;
          if (cmd_valid && cmd_ready) begin
            cmd_q     <= cmd;
            data_left <= cmd.byte_count;
            sr        <= opcode(cmd);
            bit_cnt   <= 3'h0;
            hdr_cnt   <= 3'h1;
            cs_n      <= 1'b0;
            state     <= st_low;
          end
        end
        st_low: begin
          // si already holds the bit; one half of setup before the rise
          if (half_done) begin
            sck   <= 1'b1;
            state <= st_high;
          end
        end
        st_high: begin
          if (half_done) begin
            sck <= 1'b0;
            if (bit_cnt != `LAST_BIT) begin
              sr      <= {sr[6:0], 1'b0};
              bit_cnt <= bit_cnt + 3'h1;
              state   <= st_low;
            end else if (hdr_cnt != `HDR_BYTES) begin
              // chip select stays low through the whole header
              bit_cnt <= 3'h0;
              hdr_cnt <= hdr_cnt + 3'h1;
              state   <= st_low;
              case (hdr_cnt)
                3'h1:    sr <= addr[23:16];
                3'h2:    sr <= addr[15:8];
                default: sr <= addr[7:0];
              endcase
            end else if (has_data && data_left != 10'h000) begin
              bit_cnt <= 3'h0;
              state   <= st_load;
            end else begin
              // rise only after the full header: this launches the job
              cs_n  <= 1'b1;
              cnt   <= 32'h0;
              state <= st_csgap;
            end
          end
        end
        st_load: begin
          // serial clock simply pauses while the stream has no byte
          if (wr_valid) begin
            sr        <= wr_data;
            data_left <= data_left - 10'h001;
            state     <= st_low;
          end
        end
        st_csgap: begin
          if (cnt >= gap_cyc - 32'h1) begin
            cnt   <= 32'h0;
            state <= self_timed ? st_settle : st_idle;
          end else begin
            cnt <= cnt + 32'h1;
          end
        end
        st_settle: begin
          // the pin may lag the rise; give it time to drop to busy
          if (cnt >= settle_cyc - 32'h1) begin
            cnt   <= 32'h0;
            state <= st_poll;
          end else begin
            cnt <= cnt + 32'h1;
          end
        end
        st_poll: begin
          if (flash_ready || cnt >= limit_cyc - 32'h1) begin
            cnt   <= 32'h0;
            state <= st_idle;
          end else begin
            cnt <= cnt + 32'h1;
          end
        end
        default: begin
          cs_n  <= 1'b1;
          sck   <= 1'b0;
          state <= st_idle;
        end
      endcase
    end
  end

  // one-cycle completion pulse at the end of every command
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      done <= 1'b0;
    end else if (state == st_csgap && !self_timed &&
                 cnt >= gap_cyc - 32'h1) begin
      done <= 1'b1;
    end else if (state == st_poll &&
                 (flash_ready || cnt >= limit_cyc - 32'h1)) begin
      done <= 1'b1;
    end else begin
      done <= 1'b0;
    end
  end

  // sticky timeout; the next accepted command clears it, the set wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timeout_err <= 1'b0;
    end else if (state == st_poll && !flash_ready &&
                 cnt >= limit_cyc - 32'h1) begin
      timeout_err <= 1'b1;
    end else if (cmd_valid && cmd_ready) begin
      timeout_err <= 1'b0;
    end
  end

endmodule : flash_program_host

// File: inc/flash_cmd_regs.svh
// Purpose: opcodes, frame layout and timing counts for the flash host
// Assumes: core clock of 10 MHz; serial clock made here by a divider
// Notes:   definitions only
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH

`define OPC_BUF1_LOAD     8'h84
`define OPC_BUF2_LOAD     8'h87
`define OPC_BUF1_PROG_ER  8'h83
`define OPC_BUF2_PROG_ER  8'h86
`define OPC_BUF1_PROG_NE  8'h88
`define OPC_BUF2_PROG_NE  8'h89
`define OPC_PAGE_ERASE    8'h81
`define OPC_BLOCK_ERASE   8'h50
`define OPC_BUF1_PROG_TH  8'h82
`define OPC_BUF2_PROG_TH  8'h85
`define OPC_BUF1_COPY     8'h53
`define OPC_BUF2_COPY     8'h55
`define OPC_BUF1_REWRITE  8'h58
`define OPC_BUF2_REWRITE  8'h59

// frame: one opcode byte, then three address bytes, msb first
`define HDR_BYTES         3'h4
`define LAST_BIT          3'h7
`define PAGE_BITS         13
`define POS_BITS          10
`define LOAD_PAD_BITS     14
`define PAGE_PAD_BITS     10
`define BLOCK_PAD_BITS    13

// core clock and the times the host keeps on the link
`define CLK_PERIOD_NS     100
`define SCK_HALF_NS       200
`define SCK_HALF_CYC      ((`SCK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CS_HIGH_NS        300
`define CS_HIGH_CYC       ((`CS_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_SETTLE_NS    500
`define BUSY_SETTLE_CYC   ((`BUSY_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: inc/flash_cmd_pkg.sv
// Purpose: types shared by the flash host and its bench
// Assumes: constants live in flash_cmd_regs.svh
// Notes:   none
package flash_cmd_pkg;

  typedef enum logic [2:0] {
    op_buf_load,
    op_prog_erase,
    op_prog_no_erase,
    op_page_erase,
    op_block_erase,
    op_prog_through,
    op_page_copy,
    op_auto_rewrite
  } op_e;

  typedef struct packed {
    op_e         op;
    logic        buf2;
    logic [12:0] page_number_bits;
    logic [9:0]  buffer_byte_position;
    logic [9:0]  byte_count;
  } cmd_s;

endpackage : flash_cmd_pkg

// File: dv/flash_dev_model.sv
// Purpose: behavioural flash on the serial link
// Assumes: mode 0 link; pin high when ready
// Notes:   keeps the last frame for the bench
`timescale 1ns/10ps
module flash_dev_model (
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si,
  input  wire logic [31:0] busy_ns,
  output logic             rdy_busy_pin,
  output logic [31:0]      hdr,
  output logic [31:0]      tail,
  output int               nbits,
  output int               launches
);
  initial begin
    rdy_busy_pin = 1'b1;
    nbits = 0;
    launches = 0;
  end
  always @(negedge cs_n) nbits = 0;
  always @(posedge sck) begin
    if (!cs_n) begin
      tail = {tail[30:0], si};
      nbits = nbits + 1;
      if (nbits == 32) hdr = tail;
    end
  end
  // a cut header or a frame while busy is dropped
  always @(posedge cs_n) begin
    if (nbits >= 32 && rdy_busy_pin && !(hdr[31:24] inside {8'h84, 8'h87}))
    begin
      launches = launches + 1;
      #100 rdy_busy_pin = 1'b0;
      #(busy_ns) rdy_busy_pin = 1'b1;
    end
  end
endmodule : flash_dev_model

// File: dv/flash_program_host_monitor.sv
// Purpose: port checks of the flash program host
// Assumes: link clock divided from the core clock
// Notes:   bound below
`timescale 1ns/10ps
module flash_program_host_monitor
  import flash_cmd_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = 32'd1000000
) (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire cmd_s       cmd,
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire logic [7:0] wr_data,
  input wire logic       busy,
  input wire logic       done,
  input wire logic       timeout_err,
  input wire logic       flash_ready,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic       si,
  input wire logic       rdy_busy_pin
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_ready_gate: assert property (cmd_ready |-> flash_ready && !busy)
    else $error("ready while busy");
  chk_accept_frame: assert property (
    cmd_valid && cmd_ready |=> !cs_n && busy)
    else $error("no frame start");
  chk_select_busy: assert property (!cs_n |-> busy)
    else $error("select while idle");
  chk_sck_idle: assert property (cs_n |-> !sck)
    else $error("clock outside frame");
  chk_si_settled: assert property ($rose(sck) |-> $stable(si))
    else $error("data moved at rise");
  chk_sck_half: assert property ($rose(sck) |=> sck ##1 !sck)
    else $error("clock half period");
  chk_done_pulse: assert property (done |=> !done)
    else $error("done too long");
  chk_timeout_done: assert property ($rose(timeout_err) |-> done)
    else $error("timeout without done");
  cover property (cmd_valid && cmd_ready);
  cover property (wr_valid && wr_ready);
  cover property ($rose(timeout_err));
endmodule : flash_program_host_monitor

bind flash_program_host flash_program_host_monitor #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) mon_u (
  .core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd(cmd), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_data(wr_data), .busy(busy), .done(done),
  .timeout_err(timeout_err), .flash_ready(flash_ready), .cs_n(cs_n),
  .sck(sck), .si(si), .rdy_busy_pin(rdy_busy_pin)
);

// File: dv/test_flash_program_host.sv
// Purpose: self-checking bench of the flash program host
// Assumes: device model answers on the ready pin
// Notes:   short poll limit keeps the timeout case quick
`timescale 1ns/10ps
module test_flash_program_host
  import flash_cmd_pkg::*;
();
  localparam int LIM = 60000;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        wr_valid = 1'b0;
  logic [7:0]  wr_data = 8'h00;
  cmd_s        cmd = '0;
  logic        cmd_ready, wr_ready, busy, done, timeout_err;
  logic        flash_ready, cs_n, sck, si, rdy_busy_pin;
  logic [31:0] hdr, tail;
  logic [31:0] busy_ns = 32'd3000;
  logic [7:0]  dbytes [4];
  int          nbits, launches, wi, nb, exp_launch;
  int          err_total = 0;
  int          checks = 0;
  integer      seed = 32'hD3FE6730;
  op_e         order [8] = '{op_page_erase, op_prog_no_erase, op_buf_load,
    op_prog_erase, op_block_erase, op_prog_through, op_page_copy,
    op_auto_rewrite};  // erase comes before plain program

  flash_program_host #(.TIMEOUT_CYCLES(200)) dut_u (
    .core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .busy(busy), .done(done),
    .timeout_err(timeout_err), .flash_ready(flash_ready), .cs_n(cs_n),
    .sck(sck), .si(si), .rdy_busy_pin(rdy_busy_pin));
  flash_dev_model dev_u (
    .sck(sck), .cs_n(cs_n), .si(si), .busy_ns(busy_ns),
    .rdy_busy_pin(rdy_busy_pin), .hdr(hdr), .tail(tail), .nbits(nbits),
    .launches(launches));

  always #50 core_clk = ~core_clk;

  // random stalls on the data side; a raised valid holds until taken
  always @(posedge core_clk) begin
    if (wr_valid && wr_ready) wi = wi + 1;
    if (!wr_valid || wr_ready) begin
      wr_valid <= (wi < nb) && ($random(seed) % 4 != 0);
      wr_data <= dbytes[wi % 4];
    end
  end

  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic run(cmd_s c);
    int k;
    @(posedge core_clk);
    cmd <= c;
    cmd_valid <= 1'b1;
    for (k = 0; k < LIM && cmd_ready !== 1'b1; k++) @(negedge core_clk);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    for (k = k; k < LIM && done !== 1'b1; k++) @(negedge core_clk);
    if (k >= LIM) begin
      err_total++;
      end_sim();
    end
  endtask : run

  function automatic logic [31:0] exp_hdr(cmd_s c);
    logic [7:0] o;
    case (c.op)
      op_buf_load:      o = c.buf2 ? 8'h87 : 8'h84;
      op_prog_erase:    o = c.buf2 ? 8'h86 : 8'h83;
      op_prog_no_erase: o = c.buf2 ? 8'h89 : 8'h88;
      op_page_erase:    o = 8'h81;
      op_block_erase:   o = 8'h50;
      op_prog_through:  o = c.buf2 ? 8'h85 : 8'h82;
      op_page_copy:     o = c.buf2 ? 8'h55 : 8'h53;
      default:          o = c.buf2 ? 8'h59 : 8'h58;
    endcase
    case (c.op)
      op_buf_load:     return {o, 14'h0, c.buffer_byte_position};
      op_prog_through: return {o, 1'b0, c.page_number_bits,
                               c.buffer_byte_position};
      op_block_erase:  return {o, 1'b0, c.page_number_bits[12:3], 13'h0};
      default:         return {o, 1'b0, c.page_number_bits, 10'h0};
    endcase
  endfunction : exp_hdr

  initial begin
    cmd_s c;
    int b, i, j;
    exp_launch = 0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    for (b = 0; b < 2; b++) begin
      c.page_number_bits = 13'($random(seed));
      for (i = 0; i < 8; i++) begin
        c.op = order[i];
        c.buf2 = b[0];
        c.buffer_byte_position = 10'($random(seed));
        nb = (c.op inside {op_buf_load, op_prog_through}) ? i % 3 + 1 + b : 0;
        c.byte_count = 10'(nb);
        wi = 0;
        for (j = 0; j < 4; j++) dbytes[j] = 8'($random(seed));
        if (c.op != op_buf_load) exp_launch++;
        run(c);
        cmp("opcode", exp_hdr(c) >> 24, hdr >> 24);
        cmp("header", exp_hdr(c), hdr);
        cmp("busy", 0, busy);
        cmp("bits", 32 + 8 * nb, nbits);
        if (nb > 0) cmp("last byte", dbytes[nb - 1], tail[7:0]);
        cmp("launches", exp_launch, launches);
        cmp("timeout", 0, timeout_err);
      end
    end
    busy_ns = 32'd50000;
    c.op = op_page_erase;
    nb = 0;
    exp_launch++;
    run(c);
    cmp("timeout", 1, timeout_err);
    cmp("ready", 0, flash_ready);
    busy_ns = 32'd3000;
    exp_launch++;
    run(c);
    cmp("timeout", 0, timeout_err);
    cmp("launches", exp_launch, launches);
    end_sim();
  end
endmodule : test_flash_program_host
